// ==== rtl/ptb_time_base_ctrl.sv ====
// Top of the PWM time base control: control register, idle gating, prescale and postscale ticks
`timescale 1ns/10ps
module ptb_time_base_ctrl (
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic [ptb_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [ptb_pkg::DATA_W-1:0]  regWrData,
  input  wire logic                        regWrite,
  input  wire logic                        regRead,
  output logic      [ptb_pkg::DATA_W-1:0]  regRdData,
  input  wire logic                        cpuIdle,
  output logic                             timeBaseActive,
  output logic                             countTick,
  output logic                             postscaleTick,
  output ptb_pkg::ptb_mode_t               countMode
);

  logic [ptb_pkg::DATA_W-1:0] pwm_time_base_control;
  ptb_pkg::ptb_ctrl_t         ctrl;
  logic                       idleMeta;
  logic                       idleSync;
  logic                       running;
  logic [5:0]                 preLimit;
  logic                       preTick;
  logic                       postTick;

  // Control register write; unimplemented bits never stored
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_time_base_control <= ptb_pkg::CTRL_RESET;
    end else if (regWrite && regAddr == ptb_pkg::CTRL_ADDR) begin
      pwm_time_base_control <= regWrData & ptb_pkg::CTRL_MASK;
    end
  end

  // Read data valid the cycle after the strobe; zero elsewhere
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= '0;
    end else if (regRead && regAddr == ptb_pkg::CTRL_ADDR) begin
      regRdData <= pwm_time_base_control & ptb_pkg::CTRL_MASK;
    end else begin
      regRdData <= '0;
    end
  end

  // Field decode
  assign ctrl.timeBaseRun        = pwm_time_base_control[ptb_pkg::RUN_BIT];
  assign ctrl.haltInIdle         = pwm_time_base_control[ptb_pkg::IDLE_BIT];
  assign ctrl.outputPostscaleSel = pwm_time_base_control[ptb_pkg::POST_LSB +: 4];
  assign ctrl.inputPrescaleSel   = ptb_pkg::ptb_pre_t'(pwm_time_base_control[ptb_pkg::PRE_LSB +: 2]);
  assign ctrl.countModeSel       = ptb_pkg::ptb_mode_t'(pwm_time_base_control[ptb_pkg::MODE_LSB +: 2]);

  // Idle indication from the core is synchronised
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      idleMeta <= 1'b0;
      idleSync <= 1'b0;
    end else begin
      idleMeta <= cpuIdle;
      idleSync <= idleMeta;
    end
  end

  // Run when enabled and not halted by idle
  assign running = ctrl.timeBaseRun && !(ctrl.haltInIdle && idleSync);

  // Prescale limit select
  always_comb begin
    case (ctrl.inputPrescaleSel)
      ptb_pkg::PTB_PRE_1:  preLimit = ptb_pkg::PRE_DIV_1;
      ptb_pkg::PTB_PRE_4:  preLimit = ptb_pkg::PRE_DIV_4;
      ptb_pkg::PTB_PRE_16: preLimit = ptb_pkg::PRE_DIV_16;
      ptb_pkg::PTB_PRE_64: preLimit = ptb_pkg::PRE_DIV_64;
      default:             preLimit = ptb_pkg::PRE_DIV_1;
    endcase
  end

  // Input prescaler, one instruction cycle per clock
  ptb_divider #(.WIDTH(6)) u_pre (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .run     (running),
    .tickIn  (1'b1),
    .limit   (preLimit),
    .tickOut (preTick)
  );

  // Output postscaler 1:(n+1)
  ptb_divider #(.WIDTH(4)) u_post (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .run     (running),
    .tickIn  (preTick),
    .limit   (ctrl.outputPostscaleSel),
    .tickOut (postTick)
  );

  // Run status, one cycle behind the gated enable
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      timeBaseActive <= 1'b0;
    end else begin
      timeBaseActive <= running;
    end
  end

  // Prescaled count pulse, suppressed as soon as the base stops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      countTick <= 1'b0;
    end else begin
      countTick <= preTick && running;
    end
  end

  // Postscaled pulse, one cycle after the count pulse that closes a group
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      postscaleTick <= 1'b0;
    end else begin
      postscaleTick <= postTick && running;
    end
  end

  // Counting mode handed to the counter logic outside
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      countMode <= ptb_pkg::PTB_FREE_RUN;
    end else begin
      countMode <= ctrl.countModeSel;
    end
  end

endmodule : ptb_time_base_ctrl

// ==== common/ptb_pkg.sv ====
// Package with register layout, field positions and encodings for the PWM time base control block
package ptb_pkg;

  localparam int unsigned DATA_W      = 16;
  localparam int unsigned ADDR_W      = 4;
  localparam logic [3:0]  CTRL_ADDR   = 4'h0;
  localparam int unsigned RUN_BIT     = 15;
  localparam int unsigned IDLE_BIT    = 13;
  localparam int unsigned POST_LSB    = 4;
  localparam int unsigned PRE_LSB     = 2;
  localparam int unsigned MODE_LSB    = 0;
  localparam logic [15:0] CTRL_MASK   = 16'hA0FF;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;

  // Prescale encodings
  typedef enum logic [1:0] {
    PTB_PRE_1  = 2'h0,
    PTB_PRE_4  = 2'h1,
    PTB_PRE_16 = 2'h2,
    PTB_PRE_64 = 2'h3
  } ptb_pre_t;

  // Counting mode encodings
  typedef enum logic [1:0] {
    PTB_FREE_RUN   = 2'h0,
    PTB_SINGLE     = 2'h1,
    PTB_UPDOWN     = 2'h2,
    PTB_UPDOWN_DBL = 2'h3
  } ptb_mode_t;

  // Decoded control settings
  typedef struct packed {
    logic      timeBaseRun;
    logic      haltInIdle;
    logic [3:0] outputPostscaleSel;
    ptb_pre_t  inputPrescaleSel;
    ptb_mode_t countModeSel;
  } ptb_ctrl_t;

  localparam logic [5:0] PRE_DIV_1  = 6'h00;
  localparam logic [5:0] PRE_DIV_4  = 6'h03;
  localparam logic [5:0] PRE_DIV_16 = 6'h0F;
  localparam logic [5:0] PRE_DIV_64 = 6'h3F;

endpackage : ptb_pkg

// ==== rtl/ptb_divider.sv ====
// Programmable tick divider: one tick per (limit+1) input ticks
`timescale 1ns/10ps
module ptb_divider #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             run,
  input  wire logic             tickIn,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  tickOut
);

  logic [WIDTH-1:0] count;

  // Counts input ticks, restarts when stopped
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count   <= '0;
      tickOut <= 1'b0;
    end else if (!run) begin
      count   <= '0;
      tickOut <= 1'b0;
    end else if (tickIn) begin
      if (count >= limit) begin
        count   <= '0;
        tickOut <= 1'b1;
      end else begin
        count   <= count + 1'b1;
        tickOut <= 1'b0;
      end
    end else begin
      tickOut <= 1'b0;
    end
  end

endmodule : ptb_divider

// ==== test/ptb_time_base_properties.sv ====
// Port assertions
`timescale 1ns/10ps
module ptb_time_base_properties (
  input logic ref_clk,
  input logic arst_n,
  input logic [3:0] regAddr,
  input logic [15:0] regWrData,
  input logic regWrite,
  input logic regRead,
  input logic [15:0] regRdData,
  input logic timeBaseActive,
  input logic countTick,
  input logic postscaleTick,
  input logic cpuIdle,
  input ptb_pkg::ptb_mode_t countMode
);
  logic ctrlRd;
  // Control read marker
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n) ctrlRd <= 1'h0;
    else ctrlRd <= regRead && !regAddr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_rd_quiet: assert property (!$past(regRead) |-> !regRdData) else $error("data");
  a_rd_unmapped: assert property ($past(regRead) && !ctrlRd |-> !regRdData) else $error("map");
  a_rd_reserved: assert property (ctrlRd |-> !(regRdData & 16'h5F00)) else $error("bits");
  a_run_bit: assert property (ctrlRd && !regRdData[13] |-> timeBaseActive == regRdData[15]) else $error("run");
  a_enable_delay: assert property (regWrite && !regAddr && regWrData[15] && !(regWrData[13] && $past(cpuIdle))
    |-> ##2 timeBaseActive) else $error("on");
  a_idle_halt: assert property (ctrlRd |-> timeBaseActive == (regRdData[15] && !(regRdData[13] && $past(cpuIdle, 3))))
    else $error("idle");
  a_mode_copy: assert property (ctrlRd |-> countMode == regRdData[1:0]) else $error("mode");
  a_stop_quiet: assert property (!timeBaseActive |-> !countTick && !postscaleTick) else $error("tick");
  a_post_count: assert property (postscaleTick |-> $past(countTick)) else $error("post");
endmodule : ptb_time_base_properties
bind ptb_time_base_ctrl ptb_time_base_properties u_props (.*);

// ==== test/testbench.sv ====
// Time base bench
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 1'h0, arst_n = 1'h0, regWrite = 1'h0, regRead = 1'h0, cpuIdle = 1'h0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000, regRdData;
  logic timeBaseActive, countTick, postscaleTick;
  ptb_pkg::ptb_mode_t countMode;
  int nErrors = 0, checked = 0, n, c;
  ptb_time_base_ctrl dut (.*);
  // Clock at 125 MHz
  always #4 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] got, exp);
    checked++;
    nErrors += got !== exp;
    if (got !== exp) $display("MISMATCH %0t got %h", $time, got);
  endtask : chk
  task automatic stopTest(input int e);
    nErrors += e;
    if (nErrors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stopTest
  // Bus cycle; a read must return d
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= w;
    regRead <= !w;
    @(posedge ref_clk);
    regWrite <= 1'h0;
    regRead <= 1'h0;
    @(negedge ref_clk);
    if (!w) chk(regRdData, d);
  endtask : bus
  // Cycles up to the next count pulse (sel 0) or postscale pulse (sel 1)
  task automatic waitTick(input logic sel);
    c = 0;
    do begin
      @(negedge ref_clk);
      c++;
      if (c > 4000) stopTest(1);
    end while ((sel ? postscaleTick : countTick) !== 1'h1);
  endtask : waitTick
  // Main sequence
  initial begin
    n = $urandom(44624);
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'h1;
    bus(1'h0, 4'h0, 16'h0000);
    chk({15'h0, timeBaseActive}, 16'h0000);
    chk(16'(countMode), 16'h0000);
    bus(1'h1, 4'h0, 16'hFFFF);
    bus(1'h0, 4'h0, 16'hA0FF);
    bus(1'h0, 4'h9, 16'h0000);
    for (int p = 0; p < 4; p++) begin
      n = $urandom % 16;
      bus(1'h1, 4'h0, 16'(n * 16 + p * 5));
      bus(1'h1, 4'h0, 16'(n * 16 + p * 5) | 16'h8000);
      chk(16'(countMode), 16'(p));
      repeat (2) waitTick(1'h0);
      chk(16'(c), 16'(4 ** p));
      repeat (2) waitTick(1'h1);
      chk(16'(c), 16'((n + 1) * 4 ** p));
    end
    bus(1'h1, 4'h0, 16'hA000);
    @(posedge ref_clk) cpuIdle <= 1'h1;
    repeat (4) @(posedge ref_clk);
    bus(1'h0, 4'h0, 16'hA000);
    chk({15'h0, timeBaseActive}, 16'h0000);
    bus(1'h1, 4'h0, 16'h8000);
    bus(1'h0, 4'h0, 16'h8000);
    chk({15'h0, timeBaseActive}, 16'h0001);
    stopTest(0);
  end
endmodule : testbench
